// *** logic/jesd_link_consts.svh ***
`ifndef JESD_LINK_CONSTS_SVH
`define JESD_LINK_CONSTS_SVH

// ==================================================================
// register offsets
`define ADDR_LINK_CONTROL 8'h00
`define ADDR_LINK_TEST_AND_LMFC_MASK 8'h02
`define ADDR_MULTIFRAME_COUNT_CONTROL 8'h03
`define ADDR_SCRAMBLER_CONTROL 8'h05
`define ADDR_FRAMES_PER_MULTIFRAME 8'h06
`define ADDR_LINK_SUBCLASS_SELECT 8'h07
`define ADDR_LINK_STATUS 8'h08

// ==================================================================
// field positions
`define K_OVERRIDE_BIT 7
`define TEST_SELECT_HI 7
`define TEST_SELECT_LO 5
`define DISPARITY_FLIP_BIT 4
`define RESET_MASK_BIT 3
`define FORCE_COUNT_BIT 7
`define START_VALUE_HI 6
`define START_VALUE_LO 2
`define RELEASE_DELAY_HI 1
`define RELEASE_DELAY_LO 0
`define SCRAMBLE_BIT 7
`define FRAMES_HI 4
`define FRAMES_LO 0
`define SUBCLASS_BIT 3
`define STATUS_STATE_HI 7
`define STATUS_STATE_LO 6
`define STATUS_COUNT_HI 4
`define STATUS_COUNT_LO 0

// ==================================================================
// reset values and counts
`define FRAMES_FIELD_RESET 5'h08
`define FRAMES_DEFAULT_MINUS_ONE 5'h04
`define SUBCLASS_RESET 1'h1
`define SYNC_END_COUNT 5'h1F
`define ILAS_MULTIFRAMES 2'h3
`define RPAT_LAST_OCTET 4'hB

`endif

// *** logic/jesd_link_pkg.sv ***
package jesd_link_pkg;

    // link test selections
    typedef enum logic [2:0] {
        TEST_NORMAL = 3'h0,
        TEST_D21_5 = 3'h1,
        TEST_K28_5 = 3'h2,
        TEST_REPEAT_ILAS = 3'h3,
        TEST_RPAT = 3'h4
    } link_test_e;

    // link sequence, gray along sync -> release -> ilas -> data
    typedef enum logic [1:0] {
        ST_SYNC = 2'h0,
        ST_RELEASE = 2'h1,
        ST_ILAS = 2'h3,
        ST_DATA = 2'h2
    } link_state_e;

    // what the lanes carry
    typedef enum logic [2:0] {
        SRC_SAMPLES = 3'h0,
        SRC_D21_5 = 3'h1,
        SRC_K28_5 = 3'h2,
        SRC_ILAS = 3'h3,
        SRC_RPAT = 3'h4
    } lane_source_e;

endpackage : jesd_link_pkg

// *** logic/multiframe_counter.sv ***
`timescale 1ns/100ps
`include "jesd_link_consts.svh"

module multiframe_counter (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] frames_minus_one,
    input wire logic restart,
    input wire logic [4:0] start_value,
    output logic [4:0] frame_count,
    output logic [4:0] mf_count,
    output logic mf_end
);

    logic [4:0] frame_r;
    logic [4:0] mf_r;

    // ==================================================================
    // frame position inside the multiframe
    assign mf_end = (frame_r == frames_minus_one);
    assign frame_count = frame_r;
    assign mf_count = mf_r;

    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            frame_r <= 5'h00;
        end else if (mf_end) begin
            frame_r <= 5'h00;
        end else begin
            frame_r <= frame_r + 5'h01;
        end
    end

    // multiframe count, restarts at the chosen start value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mf_r <= 5'h00;
        end else if (restart) begin
            mf_r <= start_value;
        end else if (mf_end) begin
            mf_r <= mf_r + 5'h01;
        end
    end

endmodule : multiframe_counter

// *** logic/link_sequencer.sv ***
`timescale 1ns/100ps
`include "jesd_link_consts.svh"

module link_sequencer
    import jesd_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sync_req_n,
    input wire logic [4:0] mf_count,
    input wire logic mf_end,
    input wire logic [1:0] release_delay,
    input wire logic repeat_ilas,
    output link_state_e state
);

    link_state_e state_r;
    logic [1:0] wait_r;
    logic [1:0] ilas_r;

    assign state = state_r;

    // ==================================================================
    // sync characters, release wait, alignment, data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_SYNC;
            wait_r <= 2'h0;
            ilas_r <= 2'h0;
        end else if (!sync_req_n) begin
            state_r <= ST_SYNC;
            ilas_r <= 2'h0;
        end else begin
            case (state_r)
                ST_SYNC: begin
                    if (mf_end && mf_count == `SYNC_END_COUNT) begin
                        wait_r <= release_delay;
                        state_r <= (release_delay == 2'h0) ? ST_ILAS : ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (mf_end) begin
                        wait_r <= wait_r - 2'h1;
                        if (wait_r == 2'h1) begin
                            state_r <= ST_ILAS;
                        end
                    end
                end
                ST_ILAS: begin
                    if (mf_end) begin
                        ilas_r <= ilas_r + 2'h1;
                        if (ilas_r == `ILAS_MULTIFRAMES && !repeat_ilas) begin
                            state_r <= ST_DATA;
                        end
                    end
                end
                default: begin
                    // data: repeat test sends the alignment again
                    if (repeat_ilas) begin
                        state_r <= ST_ILAS;
                    end
                end
            endcase
        end
    end

endmodule : link_sequencer

// *** logic/jesd_link_layer_config.sv ***
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "jesd_link_consts.svh"

// Overview of operation
// - test field 000 samples, 001 D21.5, 010 K28.5; codes above 100 unused
// - code 011 sends K28.5 then repeats lane alignment sequence forever
// - code 100 sends the 12-octet random jitter pattern on each lane
// - disparity flip acts only when test code is 100
// - reset mask set ignores multiframe counter reset requests
// - force bit set restarts the counter at the programmed start value
// - SYSREF resets the multiframe counter to zero, or to the forced start value, in subclass 1 only
// - K28.5 stops at the end of the release delay after the multiframe whose count is 31
// - release field delays alignment by 0 to 3 multiframes after sync
// - scrambler bit enables scrambling, cleared at reset
// - frames field gives K as value plus one, resets to 8h
// - programmed K used only with override bit, else five frames
// - subclass bit selects subclass 0 or 1, resets to 1

module jesd_link_layer_config
    import jesd_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sysref,
    input wire logic lmfc_reset_req,
    input wire logic sync_req_n,
    output lane_source_e lane_source,
    output logic [3:0] rpat_octet,
    output logic random_pattern_disparity_flip,
    output logic scramble_en,
    output logic [4:0] frames_minus_one,
    output logic subclass_one,
    output logic [4:0] mf_count,
    output logic mf_boundary
);

    // ==================================================================
    // software registers
    logic k_override_r;
    link_test_e link_test_select_r;
    logic disparity_flip_bit_r;
    logic multiframe_reset_mask_r;
    logic force_count_start_r;
    logic [4:0] multiframe_count_start_value_r;
    logic [1:0] alignment_release_delay_r;
    logic scramble_r;
    logic [4:0] frames_field_r;
    logic subclass_r;
    logic [7:0] rdata_r;

    // ==================================================================
    // block state
    logic sysref_d_r;
    logic sysref_rise;
    logic restart;
    logic [4:0] start_value;
    logic [4:0] k_minus_one;
    logic [4:0] frame_count;
    logic [4:0] mf_count_now;
    logic mf_end;
    link_state_e state;
    logic repeat_ilas;
    lane_source_e source_nxt;
    lane_source_e source_r;
    logic [3:0] rpat_r;
    logic flip_r;
    logic scramble_out_r;
    logic [4:0] k_out_r;
    logic subclass_out_r;
    logic [4:0] mf_count_r;
    logic boundary_r;

    // ==================================================================
    // register writes; reserved bits are not stored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            k_override_r <= 1'h0;
        end else if (reg_wr && reg_addr == `ADDR_LINK_CONTROL) begin
            k_override_r <= reg_wdata[`K_OVERRIDE_BIT];
        end
    end

    // test select, disparity flip and reset mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link_test_select_r <= TEST_NORMAL;
            disparity_flip_bit_r <= 1'h0;
            multiframe_reset_mask_r <= 1'h0;
        end else if (reg_wr && reg_addr == `ADDR_LINK_TEST_AND_LMFC_MASK) begin
            link_test_select_r <= link_test_e'(reg_wdata[`TEST_SELECT_HI:`TEST_SELECT_LO]);
            disparity_flip_bit_r <= reg_wdata[`DISPARITY_FLIP_BIT];
            multiframe_reset_mask_r <= reg_wdata[`RESET_MASK_BIT];
        end
    end

    // counter start control and alignment release delay
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            force_count_start_r <= 1'h0;
            multiframe_count_start_value_r <= 5'h00;
            alignment_release_delay_r <= 2'h0;
        end else if (reg_wr && reg_addr == `ADDR_MULTIFRAME_COUNT_CONTROL) begin
            force_count_start_r <= reg_wdata[`FORCE_COUNT_BIT];
            multiframe_count_start_value_r <= reg_wdata[`START_VALUE_HI:`START_VALUE_LO];
            alignment_release_delay_r <= reg_wdata[`RELEASE_DELAY_HI:`RELEASE_DELAY_LO];
        end
    end

    // scrambler enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scramble_r <= 1'h0;
        end else if (reg_wr && reg_addr == `ADDR_SCRAMBLER_CONTROL) begin
            scramble_r <= reg_wdata[`SCRAMBLE_BIT];
        end
    end

    // frames per multiframe field
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frames_field_r <= `FRAMES_FIELD_RESET;
        end else if (reg_wr && reg_addr == `ADDR_FRAMES_PER_MULTIFRAME) begin
            frames_field_r <= reg_wdata[`FRAMES_HI:`FRAMES_LO];
        end
    end

    // subclass select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            subclass_r <= `SUBCLASS_RESET;
        end else if (reg_wr && reg_addr == `ADDR_LINK_SUBCLASS_SELECT) begin
            subclass_r <= reg_wdata[`SUBCLASS_BIT];
        end
    end

    // ==================================================================
    // read data, one cycle after the strobe; reserved bits read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_LINK_CONTROL) begin
                rdata_r <= {k_override_r, 7'h00};
            end else if (reg_addr == `ADDR_LINK_TEST_AND_LMFC_MASK) begin
                rdata_r <= {link_test_select_r, disparity_flip_bit_r,
                            multiframe_reset_mask_r, 3'h0};
            end else if (reg_addr == `ADDR_MULTIFRAME_COUNT_CONTROL) begin
                rdata_r <= {force_count_start_r, multiframe_count_start_value_r,
                            alignment_release_delay_r};
            end else if (reg_addr == `ADDR_SCRAMBLER_CONTROL) begin
                rdata_r <= {scramble_r, 7'h00};
            end else if (reg_addr == `ADDR_FRAMES_PER_MULTIFRAME) begin
                rdata_r <= {3'h0, frames_field_r};
            end else if (reg_addr == `ADDR_LINK_SUBCLASS_SELECT) begin
                rdata_r <= {4'h0, subclass_r, 3'h0};
            end else if (reg_addr == `ADDR_LINK_STATUS) begin
                rdata_r <= {state, 1'h0, mf_count_now};
            end else begin
                rdata_r <= 8'h00; // unmapped
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ==================================================================
    // sysref edge; counter restart requests pass the mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sysref_d_r <= 1'h0;
        end else begin
            sysref_d_r <= sysref;
        end
    end

    assign sysref_rise = sysref && !sysref_d_r;
    assign restart = !multiframe_reset_mask_r
                     && ((sysref_rise && subclass_r) || lmfc_reset_req);

    // start value applies only with the force bit
    assign start_value = force_count_start_r ? multiframe_count_start_value_r
                                             : 5'h00;

    // effective multiframe length
    assign k_minus_one = k_override_r ? frames_field_r
                                      : `FRAMES_DEFAULT_MINUS_ONE;

    // ==================================================================
    // local multiframe counter
    multiframe_counter u_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .frames_minus_one(k_minus_one),
        .restart(restart),
        .start_value(start_value),
        .frame_count(frame_count),
        .mf_count(mf_count_now),
        .mf_end(mf_end)
    );

    // ==================================================================
    // sync, release and alignment sequence
    assign repeat_ilas = (link_test_select_r == TEST_REPEAT_ILAS);

    link_sequencer u_sequencer (
        .ref_clk(ref_clk),
        .rst(rst),
        .sync_req_n(sync_req_n),
        .mf_count(mf_count_now),
        .mf_end(mf_end),
        .release_delay(alignment_release_delay_r),
        .repeat_ilas(repeat_ilas),
        .state(state)
    );

    // ==================================================================
    // lane payload choice
    always_comb begin
        case (link_test_select_r)
            TEST_D21_5: source_nxt = SRC_D21_5;
            TEST_K28_5: source_nxt = SRC_K28_5;
            TEST_RPAT: source_nxt = SRC_RPAT;
            default: begin
                // normal, repeat and unused codes follow the sequence
                case (state)
                    ST_ILAS: source_nxt = SRC_ILAS;
                    ST_DATA: source_nxt = SRC_SAMPLES;
                    default: source_nxt = SRC_K28_5;
                endcase
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            source_r <= SRC_K28_5;
        end else begin
            source_r <= source_nxt;
        end
    end

    // random pattern octet index, wraps after twelve octets
    always_ff @(posedge ref_clk) begin
        if (rst || source_nxt != SRC_RPAT) begin
            rpat_r <= 4'h0;
        end else if (source_r == SRC_RPAT) begin
            rpat_r <= (rpat_r == `RPAT_LAST_OCTET) ? 4'h0 : rpat_r + 4'h1;
        end
    end

    // disparity flip only in the random pattern test
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flip_r <= 1'h0;
        end else begin
            flip_r <= disparity_flip_bit_r && link_test_select_r == TEST_RPAT;
        end
    end

    // ==================================================================
    // link configuration outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scramble_out_r <= 1'h0;
            k_out_r <= `FRAMES_DEFAULT_MINUS_ONE;
            subclass_out_r <= `SUBCLASS_RESET;
        end else begin
            scramble_out_r <= scramble_r;
            k_out_r <= k_minus_one;
            subclass_out_r <= subclass_r;
        end
    end

    // counter view for the framer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mf_count_r <= 5'h00;
            boundary_r <= 1'h0;
        end else begin
            mf_count_r <= mf_count_now;
            boundary_r <= mf_end && !restart;
        end
    end

    assign reg_rdata = rdata_r;
    assign lane_source = source_r;
    assign rpat_octet = rpat_r;
    assign random_pattern_disparity_flip = flip_r;
    assign scramble_en = scramble_out_r;
    assign frames_minus_one = k_out_r;
    assign subclass_one = subclass_out_r;
    assign mf_count = mf_count_r;
    assign mf_boundary = boundary_r;

endmodule : jesd_link_layer_config

// *** sim/rx_model.sv ***
`timescale 1ns/100ps

// ==========
// receiver side
// holds a code group sync request while the bench asks for one
module rx_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold_sync,
    output logic sync_req_n
);
    // registered request, low after reset like a receiver not yet locked
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_req_n <= 1'b0;
        end else begin
            sync_req_n <= ~hold_sync;
        end
    end
endmodule : rx_model

// *** sim/jesd_link_layer_config_monitor.sv ***
`timescale 1ns/100ps

// ==========
// port checker
module jesd_link_layer_config_monitor
    import jesd_link_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sysref,
    input wire logic lmfc_reset_req,
    input wire logic sync_req_n,
    input wire lane_source_e lane_source,
    input wire logic [3:0] rpat_octet,
    input wire logic random_pattern_disparity_flip,
    input wire logic scramble_en,
    input wire logic [4:0] frames_minus_one,
    input wire logic subclass_one,
    input wire logic [4:0] mf_count,
    input wire logic mf_boundary
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // no restart cause and default multiframe length
    sequence s_quiet;
        !sysref && !lmfc_reset_req && frames_minus_one == 5'h04;
    endsequence

    // ==========
    // assertions
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_reset_vals: assert property ($fell(rst) |-> frames_minus_one == 5'h04
        && subclass_one && !scramble_en && mf_count == 5'h00)
        else $error("wrong value after reset");
    a_src_range: assert property (lane_source <= SRC_RPAT)
        else $error("lane source out of range");
    a_test_select: assert property (reg_wr && reg_addr == 8'h02
        && reg_wdata[7:5] inside {3'h1, 3'h2, 3'h4}
        |=> ##1 lane_source == $past(reg_wdata[7:5], 2))
        else $error("test pattern not selected");
    a_flip_rpat: assert property (random_pattern_disparity_flip |-> lane_source == SRC_RPAT)
        else $error("disparity flip outside random pattern");
    a_octet_range: assert property (rpat_octet <= 4'hB)
        else $error("pattern octet beyond 11");
    a_octet_wrap: assert property (rpat_octet == 4'hB |=> rpat_octet == 4'h0)
        else $error("pattern octet did not wrap");
    a_ilas_start: assert property ($rose(lane_source == SRC_ILAS) |-> mf_count <= 5'h04)
        else $error("alignment started at wrong count");
    a_scramble_wr: assert property (reg_wr && reg_addr == 8'h05
        |=> ##1 scramble_en == $past(reg_wdata[7], 2))
        else $error("scramble enable not updated");
    a_subclass_wr: assert property (reg_wr && reg_addr == 8'h07
        |=> ##1 subclass_one == $past(reg_wdata[3], 2))
        else $error("subclass not updated");
    a_mf_gap: assert property (mf_boundary && frames_minus_one != 5'h00 |=> !mf_boundary)
        else $error("boundary longer than one frame");
    a_mf_period: assert property (mf_boundary ##0 s_quiet[*6] |-> mf_boundary)
        else $error("multiframe not five frames");
endmodule : jesd_link_layer_config_monitor

// *** sim/jesd_link_layer_config_tb.sv ***
`timescale 1ns/100ps

// ==========
// testbench top
module jesd_link_layer_config_tb
    import jesd_link_pkg::*;
;
    logic ref_clk, rst, reg_wr, reg_rd, sysref, lmfc_reset_req, hold_sync, sync_req_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    lane_source_e lane_source;
    logic [3:0] rpat_octet;
    logic flip, scramble_en, subclass_one, mf_boundary;
    logic [4:0] frames_minus_one, mf_count;
    int errors = 0;
    int checks = 0;

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    jesd_link_layer_config DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .sysref, .lmfc_reset_req, .sync_req_n, .lane_source, .rpat_octet,
        .random_pattern_disparity_flip(flip), .scramble_en, .frames_minus_one,
        .subclass_one, .mf_count, .mf_boundary);
    rx_model u_rx (.ref_clk, .rst, .hold_sync, .sync_req_n);

    // ==========
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic end_sim;
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // ==========
    // scenarios
    task automatic t_reset_values;
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h08);
        rd(8'h07, 8'h08);
        rd(8'h01, 8'h00);
        chk(frames_minus_one, 8'h04);
    endtask : t_reset_values
    task automatic t_fields;
        wr(8'h05, 8'h80);
        tick(2);
        chk(scramble_en, 8'h01);
        rd(8'h05, 8'h80);
        wr(8'h07, 8'h00);
        tick(2);
        chk(subclass_one, 8'h00);
        wr(8'h07, 8'h08);
        wr(8'h06, 8'h0F);
        tick(2);
        chk(frames_minus_one, 8'h04);
        wr(8'h00, 8'h80);
        tick(2);
        chk(frames_minus_one, 8'h0F);
        wr(8'h00, 8'h00);
        wr(8'h06, 8'h08);
        wr(8'h05, 8'h00);
    endtask : t_fields
    task automatic t_test_modes;
        lane_source_e exp_src [6] = '{SRC_K28_5, SRC_D21_5, SRC_K28_5, SRC_K28_5, SRC_RPAT,
            SRC_K28_5};
        logic [3:0] prev;
        for (int c = 0; c < 6; c++) begin
            wr(8'h02, {c[2:0], 5'h10});
            tick(3);
            chk(lane_source, exp_src[c]);
            chk(flip, c == 4);
            for (int k = 0; k < 13 && c == 4; k++) begin
                prev = rpat_octet;
                tick(1);
                chk(rpat_octet, prev == 4'hB ? 4'h0 : prev + 4'h1);
            end
        end
        wr(8'h02, 8'h00);
    endtask : t_test_modes
    // cycles from a sysref edge to the start of lane alignment
    task automatic measure(input logic [7:0] v, output int n);
        @(posedge ref_clk);
        hold_sync <= 1'b1;
        wr(8'h03, v);
        tick(4);
        sysref <= 1'b1;
        tick(1);
        sysref <= 1'b0;
        hold_sync <= 1'b0;
        n = 0;
        while (lane_source !== SRC_ILAS && n < 400) begin
            tick(1);
            n++;
        end
        chk(lane_source, SRC_ILAS);
    endtask : measure
    task automatic t_release;
        int n0, n2, nf;
        measure(8'h00, n0);
        rd(8'h08, 8'hC0);
        tick(16);
        chk(lane_source, SRC_ILAS);
        tick(4);
        chk(lane_source, SRC_SAMPLES);
        measure(8'h02, n2);
        measure(8'hF0, nf);
        chk(8'(n2 - n0), 8'h0A);
        chk(8'(n0 - nf), 8'h8C);
    endtask : t_release
    task automatic t_repeat;
        int n;
        wr(8'h02, 8'h60);
        measure(8'h00, n);
        tick(60);
        chk(lane_source, SRC_ILAS);
        wr(8'h02, 8'h00);
    endtask : t_repeat
    task automatic t_mask;
        for (int i = 0; i < 4; i++) begin
            wr(8'h02, i[1] ? 8'h00 : 8'h08);
            for (int k = 0; k < 200 && (mf_count < 5'h03 || mf_count > 5'h14); k++) tick(1);
            if (i[0]) sysref <= 1'b1;
            else lmfc_reset_req <= 1'b1;
            tick(1);
            sysref <= 1'b0;
            lmfc_reset_req <= 1'b0;
            tick(2);
            chk(mf_count == 5'h00, i[1]);
            if (i[1]) begin
                tick(4);
                chk(mf_boundary, 8'h01);
            end
        end
    endtask : t_mask

    // ==========
    // main sequence and watchdog
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sysref = 1'b0;
        lmfc_reset_req = 1'b0;
        hold_sync = 1'b1;
        tick(16);
        rst <= 1'b0;
        t_reset_values;
        t_fields;
        t_test_modes;
        t_release;
        t_repeat;
        t_mask;
        end_sim;
    end
    initial begin
        #200000;
        errors++;
        end_sim;
    end
endmodule : jesd_link_layer_config_tb

bind jesd_link_layer_config jesd_link_layer_config_monitor u_mon (.ref_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sysref, .lmfc_reset_req, .sync_req_n,
    .lane_source, .rpat_octet, .random_pattern_disparity_flip, .scramble_en,
    .frames_minus_one, .subclass_one, .mf_count, .mf_boundary);
